// File: tap_port_regs.svh
// constants for the test access port pin block
// assumes a single core clock domain sampling the test clock pin
// Behaviour
// - controller supplies a gated test clock; it clocks test logic and shifting
// - test clock input held low by an internal pull-down
// - mode select sampled on each rising test clock edge to step controller
// - serial input bit sampled on each rising test clock edge
// - serial output driven only in shift-IR or shift-DR, else high impedance
// - serial output updates on the falling test clock edge
// - serial output disabled while chip reset is held
// - active-low test reset puts the controller into test-logic-reset
// - pull-ups on mode, input and reset pins; one disable bit drops all three
`ifndef TAP_PORT_REGS_SVH
`define TAP_PORT_REGS_SVH
`define TAP_IR_WIDTH 4
`define TAP_IR_RESET 4'h1
`define TAP_IR_CAPTURE 4'h1
`define TAP_IR_BYPASS 4'hf
`define TAP_DR_WIDTH 32
`endif

// File: tap_port_pkg.sv
// types for the test access port pin block
// assumes nothing beyond the constants header
package tap_port_pkg;
    typedef enum logic [3:0] {
        TLR = 4'h0, RTI = 4'h1, SELDR = 4'h2, CAPDR = 4'h3,
        SHDR = 4'h4, EX1DR = 4'h5, PADR = 4'h6, EX2DR = 4'h7,
        UPDR = 4'h8, SELIR = 4'h9, CAPIR = 4'ha, SHIR = 4'hb,
        EX1IR = 4'hc, PAIR = 4'hd, EX2IR = 4'he, UPIR = 4'hf
    } tap_state_t;
    typedef struct packed {
        logic tdo;
        logic tdoOen;
    } serial_out_t;
    typedef struct packed {
        logic tmsPull;
        logic tdiPull;
        logic trstPull;
        logic tckPullDown;
    } pull_ctl_t;
endpackage

// File: tap_port.sv
// test access port controller behind the test pins
// assumes pins arrive unsynchronised; testbench resolves pads from enables
`timescale 1ns/100ps
`include "tap_port_regs.svh"
module tap_port #(
    parameter int DR_WIDTH = `TAP_DR_WIDTH
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic testClk,
    input wire logic modeSel,
    input wire logic serialIn,
    input wire logic testRst_n,
    input wire logic pullDisable,
    output tap_port_pkg::serial_out_t serialOut,
    output tap_port_pkg::pull_ctl_t pullCtl,
    output tap_port_pkg::tap_state_t tapState,
    output logic [`TAP_IR_WIDTH-1:0] instr,
    output logic [DR_WIDTH-1:0] dataReg
);
    // ****************
    // pin synchronisers
    // ****************
    // two flops per pin; only the second flop feeds logic
    logic [1:0] tckSync_q;
    logic [1:0] tmsSync_q;
    logic [1:0] tdiSync_q;
    logic [1:0] trstSync_q;
    logic tckLast_q;
    always_ff @(posedge core_clk) begin
        tckSync_q <= {tckSync_q[0], testClk};
        tmsSync_q <= {tmsSync_q[0], modeSel};
        tdiSync_q <= {tdiSync_q[0], serialIn};
        trstSync_q <= {trstSync_q[0], testRst_n};
        tckLast_q <= rst ? 1'b0 : tckSync_q[1];
    end
    wire tckRise = tckSync_q[1] & ~tckLast_q;
    wire tckFall = ~tckSync_q[1] & tckLast_q;
    wire tms = tmsSync_q[1];
    wire tdi = tdiSync_q[1];
    wire trstActive = ~trstSync_q[1];
    // ****************
    // pull control
    // ****************
    assign pullCtl.tmsPull = ~pullDisable;
    assign pullCtl.tdiPull = ~pullDisable;
    assign pullCtl.trstPull = ~pullDisable;
    assign pullCtl.tckPullDown = 1'b1;
    // ****************
    // controller
    // ****************
    tap_port_pkg::tap_state_t state_q, state_d;
    always_comb begin
        case (state_q)
            tap_port_pkg::TLR: state_d = tms ? tap_port_pkg::TLR : tap_port_pkg::RTI;
            tap_port_pkg::RTI: state_d = tms ? tap_port_pkg::SELDR : tap_port_pkg::RTI;
            tap_port_pkg::SELDR: state_d = tms ? tap_port_pkg::SELIR : tap_port_pkg::CAPDR;
            tap_port_pkg::CAPDR: state_d = tms ? tap_port_pkg::EX1DR : tap_port_pkg::SHDR;
            tap_port_pkg::SHDR: state_d = tms ? tap_port_pkg::EX1DR : tap_port_pkg::SHDR;
            tap_port_pkg::EX1DR: state_d = tms ? tap_port_pkg::UPDR : tap_port_pkg::PADR;
            tap_port_pkg::PADR: state_d = tms ? tap_port_pkg::EX2DR : tap_port_pkg::PADR;
            tap_port_pkg::EX2DR: state_d = tms ? tap_port_pkg::UPDR : tap_port_pkg::SHDR;
            tap_port_pkg::UPDR: state_d = tms ? tap_port_pkg::SELDR : tap_port_pkg::RTI;
            tap_port_pkg::SELIR: state_d = tms ? tap_port_pkg::TLR : tap_port_pkg::CAPIR;
            tap_port_pkg::CAPIR: state_d = tms ? tap_port_pkg::EX1IR : tap_port_pkg::SHIR;
            tap_port_pkg::SHIR: state_d = tms ? tap_port_pkg::EX1IR : tap_port_pkg::SHIR;
            tap_port_pkg::EX1IR: state_d = tms ? tap_port_pkg::UPIR : tap_port_pkg::PAIR;
            tap_port_pkg::PAIR: state_d = tms ? tap_port_pkg::EX2IR : tap_port_pkg::PAIR;
            tap_port_pkg::EX2IR: state_d = tms ? tap_port_pkg::UPIR : tap_port_pkg::SHIR;
            tap_port_pkg::UPIR: state_d = tms ? tap_port_pkg::SELDR : tap_port_pkg::RTI;
            default: state_d = tap_port_pkg::TLR;
        endcase
    end
    // ****************
    // shift registers
    // ****************
    logic [`TAP_IR_WIDTH-1:0] irShift_q;
    logic [DR_WIDTH-1:0] drShift_q;
    wire inShiftIr = state_q == tap_port_pkg::SHIR;
    wire inShiftDr = state_q == tap_port_pkg::SHDR;
    wire bypassSel = instr == `TAP_IR_BYPASS;
    wire drOutBit = bypassSel ? drShift_q[DR_WIDTH-1] : drShift_q[0];
    // per-edge strobes, each one core cycle wide
    wire irCapture = tckRise && state_q == tap_port_pkg::CAPIR;
    wire irShiftEn = tckRise && inShiftIr;
    wire irUpdate = tckRise && state_q == tap_port_pkg::UPIR;
    wire drCapture = tckRise && state_q == tap_port_pkg::CAPDR;
    wire drShiftEn = tckRise && inShiftDr;
    wire drUpdate = tckRise && state_q == tap_port_pkg::UPDR && !bypassSel;
    // bypass runs lsb-in and msb-out, so its delay spans the whole register
    wire [DR_WIDTH-1:0] drShiftLeft = {drShift_q[DR_WIDTH-2:0], tdi};
    wire [DR_WIDTH-1:0] drShiftRight = {tdi, drShift_q[DR_WIDTH-1:1]};
    wire [DR_WIDTH-1:0] drShiftNext = bypassSel ? drShiftLeft : drShiftRight;
    wire [`TAP_IR_WIDTH-1:0] irShiftNext = {tdi, irShift_q[`TAP_IR_WIDTH-1:1]};
    // ****************
    // controller state
    // ****************
    always_ff @(posedge core_clk) begin
        if (trstActive) begin
            state_q <= tap_port_pkg::TLR;
        end else if (tckRise) begin
            state_q <= state_d;
        end
    end
    assign tapState = state_q;
    // ****************
    // instruction path
    // ****************
    always_ff @(posedge core_clk) begin
        if (trstActive) begin
            irShift_q <= '0;
        end else if (irCapture) begin
            irShift_q <= `TAP_IR_CAPTURE;
        end else if (irShiftEn) begin
            irShift_q <= irShiftNext;
        end
    end
    always_ff @(posedge core_clk) begin
        if (trstActive) begin
            instr <= `TAP_IR_RESET;
        end else if (irUpdate) begin
            instr <= irShift_q;
        end
    end
    // ****************
    // data path
    // ****************
    always_ff @(posedge core_clk) begin
        if (trstActive) begin
            drShift_q <= '0;
        end else if (drCapture) begin
            drShift_q <= dataReg;
        end else if (drShiftEn) begin
            drShift_q <= drShiftNext;
        end
    end
    always_ff @(posedge core_clk) begin
        if (trstActive) begin
            dataReg <= '0;
        end else if (drUpdate) begin
            dataReg <= drShift_q;
        end
    end
    // ****************
    // serial output
    // ****************
    // besides chip reset clearing the data and either reset forcing the enable off, enable and data move only on a falling edge, so both stand at the rise
    always_ff @(posedge core_clk) begin
        if (rst) begin
            serialOut.tdo <= 1'b0;
            serialOut.tdoOen <= 1'b1;
        end else if (trstActive) begin
            serialOut.tdoOen <= 1'b1;
        end else if (tckFall) begin
            serialOut.tdoOen <= ~(inShiftIr | inShiftDr);
            serialOut.tdo <= inShiftIr ? irShift_q[0] : drOutBit;
        end
    end
    // ****************
    // checks
    // ****************
    a_out_off_reset: assert property (
        @(posedge core_clk) rst |=> serialOut.tdoOen)
        else $error("serial output enabled during reset");
    a_out_off_trst: assert property (
        @(posedge core_clk) disable iff (rst) trstActive |=> serialOut.tdoOen)
        else $error("serial output enabled during test reset");
    a_out_shift_only: assert property (
        @(posedge core_clk) disable iff (rst) $fell(serialOut.tdoOen) |-> $past(inShiftIr | inShiftDr))
        else $error("serial output enabled outside shift");
    a_out_in_shift: assert property (
        @(posedge core_clk) disable iff (rst || trstActive)
        tckFall && (inShiftIr || inShiftDr) |=> !serialOut.tdoOen)
        else $error("serial output not driven in shift");
    a_out_on_fall: assert property (
        @(posedge core_clk) disable iff (rst) $changed(serialOut.tdo) |-> $past(tckFall))
        else $error("serial output changed off falling edge");
    a_out_holds: assert property (
        @(posedge core_clk) disable iff (rst || trstActive) !tckFall |=> $stable(serialOut.tdo))
        else $error("serial output moved between falling edges");
    a_out_ir_bit: assert property (
        @(posedge core_clk) disable iff (rst || trstActive)
        tckFall && inShiftIr |=> serialOut.tdo == $past(irShift_q[0]))
        else $error("wrong instruction bit on serial output");
    a_trst_resets: assert property (
        @(posedge core_clk) trstActive |=> state_q == tap_port_pkg::TLR)
        else $error("controller not reset by test reset");
    a_trst_instr: assert property (
        @(posedge core_clk) trstActive |=> instr == `TAP_IR_RESET)
        else $error("instruction not reset by test reset");
    a_state_on_rise: assert property (
        @(posedge core_clk) disable iff (rst) $changed(state_q) |-> $past(tckRise) || $past(trstActive))
        else $error("state moved without rising edge");
    a_tlr_exit: assert property (
        @(posedge core_clk) disable iff (rst || trstActive)
        state_q == tap_port_pkg::TLR && tckRise && !tms |=> state_q == tap_port_pkg::RTI)
        else $error("bad exit from test-logic-reset");
    a_tlr_hold: assert property (
        @(posedge core_clk) disable iff (trstActive)
        state_q == tap_port_pkg::TLR && tckRise && tms |=> state_q == tap_port_pkg::TLR)
        else $error("left test-logic-reset with mode select high");
    a_selir_exit: assert property (
        @(posedge core_clk) disable iff (trstActive)
        state_q == tap_port_pkg::SELIR && tckRise && tms |=> state_q == tap_port_pkg::TLR)
        else $error("bad exit from select-IR");
    a_ir_capture: assert property (
        @(posedge core_clk) disable iff (trstActive) irCapture |=> irShift_q == `TAP_IR_CAPTURE)
        else $error("instruction capture value wrong");
    a_ir_shift_in: assert property (
        @(posedge core_clk) disable iff (trstActive)
        irShiftEn |=> irShift_q[`TAP_IR_WIDTH-1] == $past(tdi))
        else $error("instruction shift took wrong input bit");
    a_dr_shift_in: assert property (
        @(posedge core_clk) disable iff (trstActive)
        drShiftEn && !bypassSel |=> drShift_q[DR_WIDTH-1] == $past(tdi))
        else $error("data shift took wrong input bit");
    a_ir_update: assert property (
        @(posedge core_clk) disable iff (trstActive) irUpdate |=> instr == $past(irShift_q))
        else $error("instruction not updated from shift register");
    a_pull_off: assert property (
        @(posedge core_clk) pullDisable |-> !(pullCtl.tmsPull | pullCtl.tdiPull | pullCtl.trstPull))
        else $error("pull-up left on");
    a_pull_on: assert property (
        @(posedge core_clk) !pullDisable |-> pullCtl.tmsPull && pullCtl.tdiPull && pullCtl.trstPull)
        else $error("pull-up off while enabled");
    a_tck_pulldown: assert property (
        @(posedge core_clk) pullCtl.tckPullDown)
        else $error("clock pull-down off");
endmodule

// File: jtag_ctl_model.sv
// external test controller model driving the test pins
// assumes the bench resolves the serial output pad from its enable
`timescale 1ns/100ps
module jtag_ctl_model (
    output logic testClk,
    output logic modeSel,
    output logic serialIn,
    output logic testRst_n,
    input wire logic tdoPad
);
    initial begin
        testClk = 1'b0;
        modeSel = 1'b1;
        serialIn = 1'b1;
        testRst_n = 1'b1;
    end
    // one gated clock period; output read just before the rise
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        modeSel = tms;
        serialIn = tdi;
        #400 tdo = tdoPad;
        testClk = 1'b1;
        #400 testClk = 1'b0;
    endtask
    task automatic hold_reset();
        testRst_n = 1'b0;
        #1000 testRst_n = 1'b1;
    endtask
endmodule

// File: jtag_test_port_pins_bench.sv
// bench for the test port pins, with a controller model on the pins
// assumes design asserts live inside the design files
`timescale 1ns/100ps
module jtag_test_port_pins_bench;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic pullDisable = 1'b0;
    wire logic testClk, modeSel, serialIn, testRst_n, tdoPad;
    tap_port_pkg::serial_out_t serialOut;
    tap_port_pkg::pull_ctl_t pullCtl;
    tap_port_pkg::tap_state_t tapState;
    logic [3:0] instr;
    logic [7:0] dataReg, got;
    int n_fail = 0;
    int n_checks = 0;
    int cycles = 0;
    assign tdoPad = serialOut.tdoOen ? 1'bz : serialOut.tdo;
    always #50 core_clk = ~core_clk;
    tap_port #(.DR_WIDTH(8)) tap_port_i (.core_clk(core_clk), .rst(rst), .testClk(testClk),
        .modeSel(modeSel), .serialIn(serialIn), .testRst_n(testRst_n),
        .pullDisable(pullDisable), .serialOut(serialOut), .pullCtl(pullCtl),
        .tapState(tapState), .instr(instr), .dataReg(dataReg));
    jtag_ctl_model jtag_ctl_model_i (.testClk(testClk), .modeSel(modeSel),
        .serialIn(serialIn), .testRst_n(testRst_n), .tdoPad(tdoPad));
    task automatic stop_test();
        if (n_fail == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            stop_test();
        end
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    // mode select bits applied lsb first, then settle
    task automatic walk(input logic [7:0] tms, input int n);
        logic t;
        for (int i = 0; i < n; i++) jtag_ctl_model_i.step(tms[i], 1'b1, t);
        #500;
    endtask
    task automatic shift(input int n, input logic [7:0] din, output logic [7:0] dout);
        dout = '0;
        for (int i = 0; i < n; i++) jtag_ctl_model_i.step(i == n - 1, din[i], dout[i]);
    endtask
    task automatic t_reset();
        jtag_ctl_model_i.hold_reset();
        #500;
        chk(tapState, tap_port_pkg::TLR);
        chk(instr, 8'h01);
        chk(serialOut.tdoOen, 8'h01);
        chk(pullCtl, 8'h0f);
        @(posedge core_clk) #1 pullDisable = 1'b1;
        @(posedge core_clk) #1 chk(pullCtl, 8'h01);
        pullDisable = 1'b0;
    endtask
    task automatic t_ir();
        walk(8'h06, 5);
        chk(tapState, tap_port_pkg::SHIR);
        chk(serialOut.tdoOen, 8'h00);
        shift(4, 8'h05, got);
        chk(got, 8'h01);
        walk(8'h01, 2);
        chk(instr, 8'h05);
        chk(serialOut.tdoOen, 8'h01);
    endtask
    task automatic t_dr();
        walk(8'h01, 3);
        shift(8, 8'ha6, got);
        walk(8'h01, 2);
        chk(dataReg, 8'ha6);
        walk(8'h01, 3);
        shift(8, 8'h3c, got);
        chk(got, 8'ha6);
        walk(8'h01, 5);
        chk(dataReg, 8'h3c);
    endtask
    task automatic t_bypass();
        walk(8'h03, 4);
        shift(4, 8'h0f, got);
        chk(got, 8'h01);
        walk(8'h01, 2);
        chk(instr, 8'h0f);
        walk(8'h01, 3);
        shift(8, 8'h55, got);
        chk(got, 8'h3c);
        walk(8'h01, 2);
        chk(dataReg, 8'h3c);
    endtask
    task automatic t_chip_rst();
        walk(8'h01, 3);
        chk(serialOut.tdoOen, 8'h00);
        @(posedge core_clk) #1 rst = 1'b1;
        repeat (2) @(posedge core_clk);
        #1 chk(serialOut.tdoOen, 8'h01);
        chk(tapState, tap_port_pkg::SHDR);
        rst = 1'b0;
        walk(8'h3f, 6);
        chk(tapState, tap_port_pkg::TLR);
    endtask
    initial begin
        repeat (2) @(posedge core_clk);
        #1 rst = 1'b0;
        t_reset();
        t_ir();
        t_dr();
        t_bypass();
        t_chip_rst();
        stop_test();
    end
endmodule
